// ===== rtl/adc_ctrl_pkg.sv
// package: register map, field positions, reset values and codes of the converter control block
// assumes: byte-addressed register port, 16-bit data path
package adc_ctrl_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [15:0] CONTROL_OFFS = 16'hF060;
  localparam logic [15:0] START_STATUS_OFFS = 16'hF061;
  localparam logic [15:0] RESULT_OFFS = 16'hF062;
  localparam logic [15:0] BANDGAP_OFFS = 16'hF064;
  localparam logic [15:0] IRQ_STATUS_OFFS = 16'hF066;
  localparam logic [15:0] IRQ_MASK_OFFS = 16'hF068;

  // ****************************************
  // field positions
  // ****************************************
  localparam int MODE_BIT = 7;
  localparam int OVS_HI_BIT = 6;
  localparam int OVS_LO_BIT = 4;
  localparam int VSRC_HI_BIT = 3;
  localparam int VSRC_LO_BIT = 2;
  localparam int START_BIT = 7;
  localparam int ACTIVE_BIT = 6;
  localparam int BANDGAP_RUN_BIT = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_BADCFG_BIT = 1;
  localparam int RESULT_LSB = 2;
  localparam int RESULT_WIDTH = 14;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] START_STATUS_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [2:0] OVS_DIV1 = 3'h0;
  localparam logic [2:0] OVS_DIV2 = 3'h1;
  localparam logic [2:0] OVS_DIV4 = 3'h2;
  localparam logic [2:0] OVS_DIV8 = 3'h3;
  localparam logic [1:0] VSRC_GPIO = 2'h0;
  localparam logic [1:0] VSRC_EXT = 2'h1;
  localparam logic [1:0] VSRC_RSVD = 2'h2;
  localparam logic [1:0] VSRC_INT = 2'h3;

  // ****************************************
  // conversion timing: modulator samples per result
  // ****************************************
  localparam logic [7:0] SAMPLES_PER_RESULT = 8'h40;

endpackage

// ===== rtl/result_hold.sv
// result holding register: keeps the last finished conversion value
// assumes: load pulse and data on core_clk; read data one cycle after read strobe
`timescale 1ns/10ps
`default_nettype none
module result_hold
  import adc_ctrl_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic load, // store new value
  input wire logic [RESULT_WIDTH-1:0] load_data, // finished conversion value
  output logic [RESULT_WIDTH-1:0] hold_q // registered stored value
);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (load) begin
      hold_q <= load_data;
    end
  end
endmodule // result_hold
`default_nettype wire

// ===== rtl/adc_ctrl.sv
// converter control: mode, oversampling divider, reference pin select and result register
// assumes: the modulator delivers a one-bit stream on core_clk; its ones are counted here into a 14-bit value
// Notes on behaviour
// - 16-bit read-only result register, 14-bit value left-aligned in upper bits.
// - result content is undefined while a conversion runs.
// - mode bit: 0 converts on start request, 1 converts continuously.
// - oversample select divides clock by 1, 2, 4, 8; codes 11x forbidden.
// - reference select 00: shared pin is a general-purpose input.
// - reference select 01: shared pin is external reference input to generator.
// - reference select 11: internal reference used and driven out on the pin.
// - in wait mode writing 1 to start begins one conversion; here start stays set, so conversions repeat until start is written 0.
// - in wait mode active flag reads 1 during conversion, 0 when idle.
// - at finish, active flag clears and new value loads into result.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  input wire logic core_clk, // system clock, 25 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [15:0] reg_addr, // register byte address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic mod_bit, // modulator bitstream, on core_clk
  input wire logic pin_in, // shared pin level, asynchronous
  output logic pin_out, // shared pin drive value
  output logic pin_oe, // shared pin drive enable
  output logic port_b_bit5_input, // synchronised general input
  output logic ext_ref_en, // pin feeds reference generator
  output logic int_ref_en, // converter uses internal reference
  output logic bandgap_en, // bandgap circuit run
  output logic mod_clk_en, // oversampling clock pulse
  output logic conv_run, // modulator enable
  output logic irq // interrupt, level high
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    CONVERT = 2'b01,
    FINISH = 2'b10
  } conv_state_e;

  conv_state_e state_reg, state_next;
  logic [7:0] control_reg;
  logic start_reg;
  logic bandgap_run_reg;
  logic [1:0] irq_status_reg, irq_mask_reg;
  logic [2:0] div_cnt_reg;
  logic [7:0] sample_cnt_reg;
  logic [RESULT_WIDTH-1:0] accum_reg;
  logic [RESULT_WIDTH-1:0] hold_q;
  logic pin_meta_reg, pin_sync_reg;
  logic done_pulse;
  logic tick;
  logic [2:0] div_limit;

  wire logic mode_cont = control_reg[MODE_BIT];
  wire logic [2:0] ovs_sel = control_reg[OVS_HI_BIT:OVS_LO_BIT];
  wire logic [1:0] vsrc_sel = control_reg[VSRC_HI_BIT:VSRC_LO_BIT];

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] offs);
    hit = (addr == offs);
  endfunction

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      control_reg <= CONTROL_RESET;
    end else if (reg_wr && hit(reg_addr, CONTROL_OFFS)) begin
      control_reg <= reg_wdata[7:0];
    end
  end

  // start bit: written by software only; it stays set until software clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
    end else if (reg_wr && hit(reg_addr, START_STATUS_OFFS)) begin
      start_reg <= reg_wdata[START_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bandgap_run_reg <= 1'b0;
    end else if (reg_wr && hit(reg_addr, BANDGAP_OFFS)) begin
      bandgap_run_reg <= reg_wdata[BANDGAP_RUN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_mask_reg <= IRQ_RESET;
    end else if (reg_wr && hit(reg_addr, IRQ_MASK_OFFS)) begin
      irq_mask_reg <= reg_wdata[1:0];
    end
  end

  // sticky events; a set in the clearing cycle wins
  wire logic badcfg_evt = (ovs_sel[2:1] == 2'b11) || (vsrc_sel == VSRC_RSVD);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status_reg <= IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg
        & ~((reg_wr && hit(reg_addr, IRQ_STATUS_OFFS)) ? reg_wdata[1:0] : 2'h0))
        | {badcfg_evt, done_pulse};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_status_reg | {badcfg_evt, done_pulse}) & irq_mask_reg);
    end
  end

  // ****************************************
  // oversampling divider
  // ****************************************
  always_comb begin
    case (ovs_sel)
      OVS_DIV1: div_limit = 3'h0;
      OVS_DIV2: div_limit = 3'h1;
      OVS_DIV4: div_limit = 3'h3;
      OVS_DIV8: div_limit = 3'h7;
      default: div_limit = 3'h7;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 3'h0;
    end else if (state_reg != CONVERT || div_cnt_reg >= div_limit) begin
      div_cnt_reg <= 3'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  assign tick = (state_reg == CONVERT) && (div_cnt_reg >= div_limit);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mod_clk_en <= 1'b0;
      conv_run <= 1'b0;
    end else begin
      mod_clk_en <= tick;
      conv_run <= (state_next == CONVERT);
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (mode_cont || start_reg) begin
          state_next = CONVERT;
        end
      end
      CONVERT: begin
        if (tick && sample_cnt_reg == SAMPLES_PER_RESULT - 8'h01) begin
          state_next = FINISH;
        end
      end
      FINISH: state_next = IDLE;
      default: state_next = IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // count ones of the bitstream over one result period
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sample_cnt_reg <= 8'h00;
      accum_reg <= '0;
    end else if (state_reg != CONVERT) begin
      sample_cnt_reg <= 8'h00;
      accum_reg <= '0;
    end else if (tick) begin
      sample_cnt_reg <= sample_cnt_reg + 8'h01;
      accum_reg <= accum_reg + {{(RESULT_WIDTH-1){1'b0}}, mod_bit};
    end
  end

  assign done_pulse = (state_reg == FINISH);

  result_hold u_result_hold (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(done_pulse),
    .load_data(accum_reg),
    .hold_q(hold_q)
  );

  // ****************************************
  // reference and pin function
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_b_bit5_input <= 1'b0;
      ext_ref_en <= 1'b0;
      int_ref_en <= 1'b0;
      pin_oe <= 1'b0;
      pin_out <= 1'b0;
      bandgap_en <= 1'b0;
    end else begin
      port_b_bit5_input <= (vsrc_sel == VSRC_GPIO) ? pin_sync_reg : 1'b0;
      ext_ref_en <= (vsrc_sel == VSRC_EXT);
      int_ref_en <= (vsrc_sel == VSRC_INT);
      pin_oe <= (vsrc_sel == VSRC_INT);
      pin_out <= (vsrc_sel == VSRC_INT) && bandgap_run_reg;
      bandgap_en <= bandgap_run_reg;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  wire logic active = (state_reg != IDLE);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, CONTROL_OFFS)) begin
        reg_rdata <= {8'h00, control_reg};
      end else if (hit(reg_addr, START_STATUS_OFFS)) begin
        reg_rdata <= {8'h00, start_reg, active, 6'h00};
      end else if (hit(reg_addr, RESULT_OFFS)) begin
        reg_rdata <= {hold_q, 2'b00};
      end else if (hit(reg_addr, BANDGAP_OFFS)) begin
        reg_rdata <= {15'h0000, bandgap_run_reg};
      end else if (hit(reg_addr, IRQ_STATUS_OFFS)) begin
        reg_rdata <= {14'h0000, irq_status_reg};
      end else if (hit(reg_addr, IRQ_MASK_OFFS)) begin
        reg_rdata <= {14'h0000, irq_mask_reg};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  finish_loads_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    done_pulse |=> (hold_q == $past(accum_reg)) && state_reg == IDLE)
    else $error("result not loaded at finish");
  start_begins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == IDLE && start_reg && !mode_cont) |=> state_reg == CONVERT)
    else $error("start did not begin conversion");
  cont_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == IDLE && mode_cont) |=> state_reg == CONVERT)
    else $error("continuous mode idle");
  div8_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tick && ovs_sel == OVS_DIV8 && $stable(ovs_sel)) |=> !tick [*7])
    else $error("divide by eight too fast");
  gpio_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (vsrc_sel == VSRC_GPIO) |=> !pin_oe && !ext_ref_en)
    else $error("pin driven in input mode");
  ext_ref_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (vsrc_sel == VSRC_EXT) |=> ext_ref_en && !pin_oe)
    else $error("external reference not selected");
  int_ref_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (vsrc_sel == VSRC_INT) |=> int_ref_en && pin_oe)
    else $error("internal reference not driven");
  result_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && hit(reg_addr, RESULT_OFFS)) |=> reg_rdata[15:2] == $past(hold_q))
    else $error("result read mismatch");

endmodule // adc_ctrl
`default_nettype wire

// ===== verification/mod_model.sv
// modulator stand-in: holds a constant bitstream level while the converter runs
// assumes: conv_run comes from the control block on core_clk
`timescale 1ns/10ps
`default_nettype none
module mod_model (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic conv_run, // modulator enable
  input wire logic level, // bitstream level for this conversion
  output logic mod_bit // modulator bitstream
);
  logic junk_reg;
  // idle line toggles so a stale level is never mistaken for data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      junk_reg <= 1'b0;
    end else begin
      junk_reg <= ~junk_reg;
    end
  end
  assign mod_bit = conv_run ? level : junk_reg;
endmodule // mod_model
`default_nettype wire

// ===== verification/tb_top.sv
// testbench: register port master, queued read checks, reference pin and conversion scenarios
// assumes: adc_ctrl and mod_model compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import adc_ctrl_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, mod_bit, pin_in, pin_out, pin_oe, port_b_bit5_input;
  logic ext_ref_en, int_ref_en, bandgap_en, mod_clk_en, conv_run, irq, level, rd_d, prev_run;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d, exp_v, msk_v;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [1:0] v;
  int error_cnt, n_checks, i, t, rises;
  integer seed;
  adc_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mod_bit(mod_bit), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_b_bit5_input(port_b_bit5_input), .ext_ref_en(ext_ref_en), .int_ref_en(int_ref_en),
    .bandgap_en(bandgap_en), .mod_clk_en(mod_clk_en), .conv_run(conv_run), .irq(irq));
  mod_model model (.core_clk(core_clk), .rst_n(rst_n), .conv_run(conv_run), .level(level),
    .mod_bit(mod_bit));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ****************************************
  // bus tasks and read monitor
  // ****************************************
  task automatic cyc(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] dat);
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      msk_v = msk_q.pop_front();
      `CHK("reg_rdata", exp_v, reg_rdata & msk_v)
    end
  end
  task automatic results;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic conv(input int o, input logic lv);
    int pulses, gap, last, k;
    level <= lv;
    wr(CONTROL_OFFS, {8'h00, 1'b0, o[2:0], 4'h4});
    wr(START_STATUS_OFFS, 16'h0080);
    wr(START_STATUS_OFFS, 16'h0000);
    rd(START_STATUS_OFFS, 16'h0040, 16'h0040);
    cyc(0);
    pulses = 0;
    gap = 0;
    last = 0;
    for (k = 0; k < 2000; k++) begin
      @(negedge core_clk);
      if (mod_clk_en) begin
        if (pulses > 0) gap = k - last;
        last = k;
        pulses++;
      end else if (!conv_run) begin
        break;
      end
    end
    if (k == 2000) error_cnt++;
    @(posedge core_clk);
    `CHK("pulses", int'(SAMPLES_PER_RESULT), pulses)
    `CHK("ovs_gap", 1 << o, gap)
    rd(START_STATUS_OFFS, 16'h0000, 16'h0040);
    rd(RESULT_OFFS, lv ? 16'h0100 : 16'h0000, 16'hFFFC);
    rd(IRQ_STATUS_OFFS, 16'h0001, 16'h0001);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h7289D3AE;
    error_cnt = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, pin_in, level} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(1);
    rd(CONTROL_OFFS, 16'h0000, 16'hFFFF);
    rd(START_STATUS_OFFS, 16'h0000, 16'h00FF);
    rd(16'hF070, 16'h0000, 16'hFFFF);
    for (i = 0; i < 4; i++) begin
      d = 16'(unsigned'($random(seed))) & 16'h0097;
      wr(CONTROL_OFFS, d);
      rd(CONTROL_OFFS, d & 16'h00FC, 16'h00FC);
    end
    wr(CONTROL_OFFS, 16'h0000);
    cyc(200);
    for (i = 0; i < 4; i++) begin
      v = i[1:0];
      if (v == VSRC_INT) wr(BANDGAP_OFFS, 16'h0001);
      wr(CONTROL_OFFS, {12'h000, v, 2'b00});
      wr(IRQ_STATUS_OFFS, 16'h0003);
      pin_in <= $random(seed);
      cyc(5);
      rd(IRQ_STATUS_OFFS, {14'h0000, v == VSRC_RSVD, 1'b0}, 16'h0002);
      cyc(0);
      @(negedge core_clk);
      if (v != VSRC_RSVD) begin
        `CHK("gpio", (v == VSRC_GPIO) ? pin_in : 1'b0, port_b_bit5_input)
        `CHK("ext_ref", v == VSRC_EXT, ext_ref_en)
        `CHK("int_ref", v == VSRC_INT, int_ref_en)
        `CHK("pin_oe", v == VSRC_INT, pin_oe)
      end
      if (v == VSRC_INT) `CHK("pin_out", 1'b1, pin_out & bandgap_en)
      @(posedge core_clk);
    end
    wr(IRQ_STATUS_OFFS, 16'h0003);
    wr(CONTROL_OFFS, 16'h0060);
    cyc(1);
    rd(IRQ_STATUS_OFFS, 16'h0002, 16'h0002);
    wr(IRQ_STATUS_OFFS, 16'h0003);
    for (i = 0; i < 4; i++) begin
      conv(i, i[0]);
      if (i == 0) begin
        cyc(2);
        @(negedge core_clk);
        `CHK("irq_masked", 1'b0, irq)
        @(posedge core_clk);
        wr(IRQ_MASK_OFFS, 16'h0001);
        cyc(2);
        @(negedge core_clk);
        `CHK("irq_on", 1'b1, irq)
        @(posedge core_clk);
        wr(IRQ_STATUS_OFFS, 16'h0001);
        wr(IRQ_MASK_OFFS, 16'h0000);
        cyc(2);
        @(negedge core_clk);
        `CHK("irq_off", 1'b0, irq)
        @(posedge core_clk);
      end
      wr(IRQ_STATUS_OFFS, 16'h0003);
    end
    wr(CONTROL_OFFS, 16'h0084);
    cyc(0);
    rises = 0;
    prev_run = 1'b0;
    for (t = 0; t < 400; t++) begin
      @(negedge core_clk);
      if (conv_run && !prev_run) rises++;
      prev_run = conv_run;
    end
    `CHK("continuous", 1'b1, rises >= 2)
    @(posedge core_clk);
    wr(CONTROL_OFFS, 16'h0004);
    cyc(300);
    @(negedge core_clk);
    `CHK("wait_idle", 1'b0, conv_run)
    @(posedge core_clk);
    results();
  end
endmodule // tb_top
`default_nettype wire
